// *** rtl/fbi_host.sv ***
// Host controller driving a boot-block flash over its parallel pins.
// Assumes flash data inputs synchronous to clk_sys_i; pins resolved outside.
`timescale 1ns/1ps
`default_nettype none
module fbi_host
  import fbi_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                clk_sys_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  // User request side
  input  wire logic                req_valid_i,
  input  wire fbi_req_t            req_i,
  input  wire fbi_cfg_t            cfg_i,
  output logic                     ready_o,
  output logic                     done_o,
  output logic [DATA_W-1:0]        rdata_o,
  output fbi_mode_t                mode_o,
  // Flash control pins
  output logic                     flash_ce_n_o,
  output logic                     flash_oe_n_o,
  output logic                     flash_we_n_o,
  output logic                     word_org_o,
  output logic [ADDR_W-1:0]        word_address_in_o,
  output logic                     ident_high_level_o,
  output logic                     unlock_high_level_o,
  output logic                     pdn_n_o,
  output logic                     wp_n_o,
  // Flash data pins
  output logic [7:0]               low_data_byte_o,
  input  wire logic [7:0]          low_data_byte_i,
  output logic                     low_data_byte_oe_o,
  output logic [6:0]               upper_data_bits_o,
  input  wire logic [6:0]          upper_data_bits_i,
  output logic                     upper_data_bits_oe_o,
  output logic                     top_data_or_byte_select_o,
  input  wire logic                top_data_or_byte_select_i,
  output logic                     top_data_or_byte_select_oe_o
);

  localparam logic [TMR_W-1:0] ACC_CNT  = TMR_W'(ACC_CYC);
  localparam logic [TMR_W-1:0] WP_CNT   = TMR_W'(WP_CYC);
  localparam logic [TMR_W-1:0] WAKE_CNT = TMR_W'(WAKE_CYC);

  fbi_state_t        s_r;
  fbi_state_t        s_nxt;
  logic              tmr_load;
  logic [TMR_W-1:0]  tmr_val;
  logic              tmr_exp;
  logic [DATA_W-1:0] dq_in;

  fbi_timer #(
    .W          (TMR_W)
  ) u_timer (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .load_i     (tmr_load),
    .load_val_i (tmr_val),
    .expired_o  (tmr_exp)
  );

  assign dq_in = {top_data_or_byte_select_i, upper_data_bits_i, low_data_byte_i};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_nxt     = s_r;
    tmr_load  = 1'b0;
    tmr_val   = ACC_CNT;
    s_nxt.done = 1'b0;
    s_nxt.unlock_hv = cfg_i.boot_unlock;
    s_nxt.wp_n      = cfg_i.boot_wp_off;
    case (s_r.st)
      ST_IDLE: begin
        if (cfg_i.pdn_req) begin
          s_nxt.pdn_n = 1'b0;
          s_nxt.ready = 1'b0;
          s_nxt.st    = ST_PDN;
        end else if (req_valid_i) begin
          s_nxt.ready     = 1'b0;
          s_nxt.word_org  = cfg_i.word_org;
          s_nxt.ce_strobe = cfg_i.ce_strobe;
          s_nxt.addr      = req_i.addr;
          // Top pin is address in byte mode, data bit in word mode
          s_nxt.dq[DATA_W-1] = cfg_i.word_org ? req_i.wdata[DATA_W-1] : req_i.byte_sel;
          s_nxt.top_oe    = 1'b1;
          if (req_i.op == OP_READ || req_i.op == OP_ID_READ) begin
            s_nxt.top_oe   = ~cfg_i.word_org;
            s_nxt.ident_hv = (req_i.op == OP_ID_READ);
            s_nxt.ce_n     = 1'b0;
            s_nxt.oe_n     = 1'b0;
            s_nxt.we_n     = 1'b1;
            tmr_load       = 1'b1;
            tmr_val        = ACC_CNT;
            s_nxt.st       = ST_R_WAIT;
          end else begin
            s_nxt.dq[DATA_W-2:0] = req_i.wdata[DATA_W-2:0];
            if (req_i.op == OP_CMD_ARRAY) begin
              s_nxt.dq[7:0] = CMD_ARRAY;
            end else if (req_i.op == OP_CMD_SIG) begin
              s_nxt.dq[7:0] = CMD_SIG;
            end
            if (req_i.op != OP_WRITE) begin
              s_nxt.dq[DATA_W-1:8] = '0;
              s_nxt.dq[DATA_W-1]   = cfg_i.word_org ? 1'b0 : req_i.byte_sel;
            end
            s_nxt.low_oe = 1'b1;
            s_nxt.up_oe  = cfg_i.word_org;
            s_nxt.oe_n   = 1'b1;
            // Chip-enable strobing parks write enable low first
            s_nxt.we_n   = ~cfg_i.ce_strobe;
            s_nxt.ce_n   = cfg_i.ce_strobe;
            s_nxt.st     = ST_W_SETUP;
          end
        end
      end
      ST_W_SETUP: begin
        s_nxt.ce_n = 1'b0;
        s_nxt.we_n = 1'b0;
        tmr_load   = 1'b1;
        tmr_val    = WP_CNT;
        s_nxt.st   = ST_W_STROBE;
      end
      ST_W_STROBE: begin
        if (tmr_exp) begin
          // Rising strobe is the flash capture point
          if (s_r.ce_strobe) begin
            s_nxt.ce_n = 1'b1;
          end else begin
            s_nxt.we_n = 1'b1;
          end
          if (s_r.dq[7:0] == CMD_ARRAY) begin
            s_nxt.mode = MODE_ARRAY;
          end else if (s_r.dq[7:0] == CMD_SIG) begin
            s_nxt.mode = MODE_IDENT;
          end else if (s_r.dq[7:0] == CMD_STATUS) begin
            s_nxt.mode = MODE_STATUS;
          end
          s_nxt.st = ST_W_HOLD;
        end
      end
      ST_W_HOLD: begin
        s_nxt.ce_n   = 1'b1;
        s_nxt.we_n   = 1'b1;
        s_nxt.low_oe = 1'b0;
        s_nxt.up_oe  = 1'b0;
        s_nxt.top_oe = 1'b0;
        s_nxt.done   = 1'b1;
        s_nxt.ready  = 1'b1;
        s_nxt.st     = ST_IDLE;
      end
      ST_R_WAIT: begin
        if (tmr_exp) begin
          if (s_r.word_org) begin
            s_nxt.rdata = dq_in;
          end else begin
            s_nxt.rdata = {BYTE_ZERO, dq_in[7:0]};
          end
          s_nxt.ce_n     = 1'b1;
          s_nxt.oe_n     = 1'b1;
          s_nxt.ident_hv = 1'b0;
          s_nxt.top_oe   = 1'b0;
          s_nxt.done     = 1'b1;
          s_nxt.ready    = 1'b1;
          s_nxt.st       = ST_IDLE;
        end
      end
      ST_PDN: begin
        s_nxt.mode = MODE_ARRAY;
        if (!cfg_i.pdn_req) begin
          s_nxt.pdn_n = 1'b1;
          tmr_load    = 1'b1;
          tmr_val     = WAKE_CNT;
          s_nxt.st    = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (tmr_exp) begin
          s_nxt.ready = 1'b1;
          s_nxt.st    = ST_IDLE;
        end
      end
      default: begin
        s_nxt = STATE_RST;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= STATE_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ready_o                      = s_r.ready;
  assign done_o                       = s_r.done;
  assign rdata_o                      = s_r.rdata;
  assign mode_o                       = s_r.mode;
  assign flash_ce_n_o                 = s_r.ce_n;
  assign flash_oe_n_o                 = s_r.oe_n;
  assign flash_we_n_o                 = s_r.we_n;
  assign word_org_o                   = s_r.word_org;
  assign word_address_in_o            = s_r.addr;
  assign ident_high_level_o           = s_r.ident_hv;
  assign unlock_high_level_o          = s_r.unlock_hv;
  assign pdn_n_o                      = s_r.pdn_n;
  assign wp_n_o                       = s_r.wp_n;
  assign low_data_byte_o              = s_r.dq[7:0];
  assign low_data_byte_oe_o           = s_r.low_oe;
  assign upper_data_bits_o            = s_r.dq[DATA_W-2:8];
  assign upper_data_bits_oe_o         = s_r.up_oe;
  assign top_data_or_byte_select_o    = s_r.dq[DATA_W-1];
  assign top_data_or_byte_select_oe_o = s_r.top_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i || !ce_i);

  logic wstrobe;
  logic rstrobe;
  assign wstrobe = !s_r.ce_n && !s_r.we_n;
  assign rstrobe = !s_r.ce_n && !s_r.oe_n;

  sequence s_wr_pulse;
    wstrobe [*5] ##1 !wstrobe;
  endsequence

  sequence s_rd_access;
    rstrobe [*6] ##1 !rstrobe ##0 done_o;
  endsequence

  a_write_oe_high: assert property (wstrobe |-> s_r.oe_n && s_r.low_oe)
    else $error("write strobe without output enable high");
  a_write_pulse_len: assert property ($rose(wstrobe) |-> s_wr_pulse)
    else $error("write strobe width wrong");
  a_read_bus_free: assert property (rstrobe |-> s_r.we_n && !s_r.low_oe && !s_r.up_oe)
    else $error("host drives data during read");
  a_read_access: assert property ($rose(rstrobe) |-> s_rd_access)
    else $error("read access window wrong");
  a_ident_level: assert property (s_r.ident_hv |-> rstrobe)
    else $error("identification level outside read");
  a_ce_strobe_we: assert property ($fell(s_r.ce_n) && s_r.ce_strobe && s_r.oe_n |-> !s_r.we_n)
    else $error("chip enable strobe without write enable low");
  a_sig_cmd_mode: assert property ($rose(wstrobe) && s_r.dq[7:0] == CMD_SIG |-> ##6 done_o && mode_o == MODE_IDENT)
    else $error("signature command did not select identification");
  a_array_cmd_mode: assert property ($rose(wstrobe) && s_r.dq[7:0] == CMD_ARRAY |-> ##6 done_o && mode_o == MODE_ARRAY)
    else $error("array command did not select array read");
  a_pdn_idle: assert property (!s_r.pdn_n |-> s_r.ce_n && s_r.oe_n && s_r.we_n && !s_r.low_oe)
    else $error("bus active during power down");
  a_wake_array: assert property ($rose(s_r.pdn_n) |-> mode_o == MODE_ARRAY)
    else $error("mode not array after wake");

endmodule
`default_nettype wire

// *** rtl/fbi_pkg.sv ***
// Package of the host-side flash parallel bus controller.
// Assumes a 100 MHz system clock and a flash part on the far side of the pins.
package fbi_pkg;

  // Clock and bus timing
  localparam int CLK_NS      = 10;
  localparam int T_ACC_NS    = 60;
  localparam int T_WP_NS     = 50;
  localparam int T_WAKE_NS   = 300;
  localparam int ACC_CYC     = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CYC    = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W       = 6;

  // Bus geometry
  localparam int ADDR_W      = 17;
  localparam int DATA_W      = 16;

  // Command codes
  localparam logic [7:0] CMD_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_SIG    = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_ID_READ, OP_CMD_ARRAY, OP_CMD_SIG
  } fbi_op_t;

  typedef enum logic [1:0] {
    MODE_ARRAY, MODE_IDENT, MODE_STATUS
  } fbi_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_W_SETUP, ST_W_STROBE, ST_W_HOLD, ST_R_WAIT, ST_PDN, ST_WAKE
  } fbi_st_t;

  typedef struct packed {
    fbi_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic                byte_sel;
    logic [DATA_W-1:0]   wdata;
  } fbi_req_t;

  typedef struct packed {
    logic word_org;
    logic ce_strobe;
    logic boot_unlock;
    logic boot_wp_off;
    logic pdn_req;
  } fbi_cfg_t;

  typedef struct packed {
    fbi_st_t             st;
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq;
    logic                low_oe;
    logic                up_oe;
    logic                top_oe;
    logic                ident_hv;
    logic                unlock_hv;
    logic                pdn_n;
    logic                wp_n;
    logic                word_org;
    logic                ce_strobe;
    logic                ready;
    logic                done;
    logic [DATA_W-1:0]   rdata;
    fbi_mode_t           mode;
  } fbi_state_t;

  localparam fbi_state_t STATE_RST = '{
    st: ST_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0,
    low_oe: 1'b0, up_oe: 1'b0, top_oe: 1'b0, ident_hv: 1'b0, unlock_hv: 1'b0,
    pdn_n: 1'b1, wp_n: 1'b0, word_org: 1'b1, ce_strobe: 1'b0, ready: 1'b1,
    done: 1'b0, rdata: '0, mode: MODE_ARRAY};

endpackage

// *** rtl/fbi_timer.sv ***
// Down counter that times strobe, access and wake intervals.
// Assumes loads come from the controller state machine in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module fbi_timer
  import fbi_pkg::*;
#(
  parameter int W = TMR_W
) (
  // Clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  // Control
  input  wire logic          load_i,
  input  wire logic [W-1:0]  load_val_i,
  output logic               expired_o
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = load_val_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
    end
  end

  // Last cycle of a loaded interval
  assign expired_o = (cnt_r == W'(1));

endmodule
`default_nettype wire

// *** sim/fbi_flash_model.sv ***
// Behavioural boot-block flash that answers the host controller pins.
// Assumes the bench resolves the shared data lanes and feeds them in as dq_i.
`timescale 1ns/1ps
`default_nettype none
module fbi_flash_model
  import fbi_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'hc3,  // Arbitrary value
  parameter int         BOOT_TOP   = 'h2000
) (
  // Strobes and qualifiers
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        word_org_i,
  input  wire logic        ident_hv_i,
  input  wire logic        unlock_hv_i,
  input  wire logic        pdn_n_i,
  input  wire logic        wp_n_i,
  // Address and data
  input  wire logic [16:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic [15:0]      dq_o,
  output logic             low_oe_o,
  output logic             up_oe_o
);
  logic [15:0] mem [32];
  fbi_mode_t   mode;
  logic [15:0] word;
  assign word = mem[addr_i[4:0]];
  assign low_oe_o = pdn_n_i & ~ce_n_i & ~oe_n_i & we_n_i;
  assign up_oe_o = low_oe_o & word_org_i;
  ////////////////////////////////////////
  always_comb begin
    if (ident_hv_i || mode == MODE_IDENT) dq_o = {BYTE_ZERO, addr_i[0] ? PART_CODE : MAKER_CODE};
    else if (mode == MODE_STATUS) dq_o = 16'h0080;
    else if (word_org_i) dq_o = word;
    else dq_o = {BYTE_ZERO, dq_i[15] ? word[15:8] : word[7:0]};
  end
  initial begin
    mode = MODE_ARRAY;
    for (int i = 0; i < 32; i++) mem[i] = 16'hffff;
  end
  // Command interface back to array read on entering power down
  always @(negedge pdn_n_i) mode = MODE_ARRAY;
  always @(posedge we_n_i or posedge ce_n_i) begin
    if (pdn_n_i === 1'b1 && oe_n_i === 1'b1 && (ce_n_i === 1'b0 || we_n_i === 1'b0)) begin
      case (dq_i[7:0])
        CMD_ARRAY:  mode = MODE_ARRAY;
        CMD_SIG:    mode = MODE_IDENT;
        CMD_STATUS: mode = MODE_STATUS;
        default: if (addr_i >= BOOT_TOP || unlock_hv_i || wp_n_i) begin
          if (word_org_i) mem[addr_i[4:0]] = dq_i;
          else if (dq_i[15]) mem[addr_i[4:0]][15:8] = dq_i[7:0];
          else mem[addr_i[4:0]][7:0] = dq_i[7:0];
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** sim/fbi_host_tb_top.sv ***
// Self-checking bench of the host flash controller against the flash model.
// Assumes fbi_pkg, fbi_host and fbi_flash_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module fbi_host_tb_top
  import fbi_pkg::*;
;
  typedef struct packed { logic rd; logic [15:0] data; fbi_mode_t mode; } fbi_note_t;
  localparam logic [7:0] MAKER = 8'h5a;  // Arbitrary value
  localparam logic [7:0] PART  = 8'hc3;  // Arbitrary value
  logic        clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, req_valid = 1'b0;
  fbi_req_t    req = '0;
  fbi_cfg_t    cfg = 5'b10000;
  logic        ready, done, ce_n, oe_n, we_n, word_org, id_hv, ul_hv, pdn_n, wp_n;
  logic        lo_oe, up_oe, top_oe, top_o, m_lo_oe, m_up_oe;
  logic [15:0] rdata, m_dq, bus, d, d2, v, pat = '0;
  logic [16:0] addr;
  logic [7:0]  lo_o, b;
  logic [2:0]  hold;
  logic [6:0]  up_o;
  fbi_mode_t   mode;
  fbi_note_t   q[$], nt;
  int          mismatches = 0, comparisons = 0;
  always #5 clk_sys = ~clk_sys;
  // Released lanes carry a moving pattern
  always @(posedge clk_sys) pat <= pat + 16'h3c5b;
  assign bus[7:0] = lo_oe ? lo_o : m_lo_oe ? m_dq[7:0] : pat[7:0];
  assign bus[14:8] = up_oe ? up_o : m_up_oe ? m_dq[14:8] : pat[14:8];
  assign bus[15] = top_oe ? top_o : m_up_oe ? m_dq[15] : pat[15];
  fbi_host dut_u (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .ce_i(ce), .req_valid_i(req_valid), .req_i(req), .cfg_i(cfg),
    .ready_o(ready), .done_o(done), .rdata_o(rdata), .mode_o(mode), .flash_ce_n_o(ce_n),
    .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .word_org_o(word_org), .word_address_in_o(addr),
    .ident_high_level_o(id_hv), .unlock_high_level_o(ul_hv), .pdn_n_o(pdn_n), .wp_n_o(wp_n),
    .low_data_byte_o(lo_o), .low_data_byte_i(bus[7:0]), .low_data_byte_oe_o(lo_oe),
    .upper_data_bits_o(up_o), .upper_data_bits_i(bus[14:8]), .upper_data_bits_oe_o(up_oe),
    .top_data_or_byte_select_o(top_o), .top_data_or_byte_select_i(bus[15]),
    .top_data_or_byte_select_oe_o(top_oe));
  fbi_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) model_u (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .word_org_i(word_org), .ident_hv_i(id_hv),
    .unlock_hv_i(ul_hv), .pdn_n_i(pdn_n), .wp_n_i(wp_n), .addr_i(addr), .dq_i(bus), .dq_o(m_dq),
    .low_oe_o(m_lo_oe), .up_oe_o(m_up_oe));
  ////////////////////////////////////////
  function automatic logic [15:0] rnd();
    return {8'($urandom), 8'h01 + 8'($urandom % 64)};
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    complete_run();
  endtask
  task automatic xfer(input fbi_op_t op, input logic [16:0] a, input logic bs, input logic [15:0] wd,
                      input logic [15:0] e, input fbi_mode_t m);
    int n;
    q.push_back('{op == OP_READ || op == OP_ID_READ, e, m});
    for (n = 0; n < 60 && ready !== 1'b1; n++) @(negedge clk_sys);
    if (n == 60) hang();
    req = '{op, a, bs, wd};
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    for (n = 0; n < 20 && done !== 1'b1; n++) @(negedge clk_sys);
    if (n == 20) hang();
  endtask
  // Result watcher
  always @(negedge clk_sys) begin
    if (done === 1'b1) begin
      if (q.size() == 0) hang();
      nt = q.pop_front();
      if (nt.rd) `CHK("rdata", nt.data, rdata)
      `CHK("mode", nt.mode, mode)
    end
  end
  initial begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    v = 16'($urandom(84));
    `CHK("ready", 1'b1, ready)
    `CHK("mode", MODE_ARRAY, mode)
    `CHK("pdn", 1'b1, pdn_n)
    `CHK("standby", 1'b0, m_lo_oe | lo_oe)
    $display("reset test done");
    d = rnd();
    xfer(OP_WRITE, 17'h04010, 1'b0, d, '0, MODE_ARRAY);
    xfer(OP_READ, 17'h04010, 1'b0, '0, d, MODE_ARRAY);
    cfg.ce_strobe = 1'b1;
    d2 = rnd();
    xfer(OP_WRITE, 17'h04011, 1'b0, d2, '0, MODE_ARRAY);
    xfer(OP_READ, 17'h04011, 1'b0, '0, d2, MODE_ARRAY);
    $display("word and chip strobe test done");
    cfg.word_org = 1'b0;
    b = 8'h01 + 8'($urandom % 64);
    xfer(OP_WRITE, 17'h04010, 1'b1, {8'h00, b}, '0, MODE_ARRAY);
    xfer(OP_READ, 17'h04010, 1'b1, '0, {8'h00, b}, MODE_ARRAY);
    xfer(OP_READ, 17'h04010, 1'b0, '0, {8'h00, d[7:0]}, MODE_ARRAY);
    $display("byte test done");
    for (int i = 0; i < 4; i++) begin
      cfg.word_org = i[1];
      xfer(OP_ID_READ, {16'($urandom), i[0]}, ~i[0], '0, {8'h00, i[0] ? PART : MAKER}, MODE_ARRAY);
    end
    $display("identification level test done");
    cfg.word_org = 1'b1;
    xfer(OP_CMD_SIG, 17'h04010, 1'b0, '0, '0, MODE_IDENT);
    xfer(OP_READ, 17'h00001, 1'b0, '0, {8'h00, PART}, MODE_IDENT);
    xfer(OP_WRITE, 17'h04010, 1'b0, 16'h0070, '0, MODE_STATUS);
    xfer(OP_READ, 17'h04010, 1'b0, '0, 16'h0080, MODE_STATUS);
    xfer(OP_CMD_ARRAY, 17'h04010, 1'b0, '0, '0, MODE_ARRAY);
    xfer(OP_READ, 17'h04010, 1'b0, '0, {b, d[7:0]}, MODE_ARRAY);
    $display("command test done");
    for (int i = 0; i < 3; i++) begin
      cfg.boot_wp_off = (i == 1);
      cfg.boot_unlock = (i == 2);
      v = rnd();
      xfer(OP_WRITE, 17'(5 + i), 1'b0, v, '0, MODE_ARRAY);
      xfer(OP_READ, 17'(5 + i), 1'b0, '0, i == 0 ? 16'hffff : v, MODE_ARRAY);
      `CHK("wp", cfg.boot_wp_off, wp_n)
      `CHK("unlock", cfg.boot_unlock, ul_hv)
    end
    $display("boot protection test done");
    xfer(OP_CMD_SIG, 17'h00000, 1'b0, '0, '0, MODE_IDENT);
    cfg.pdn_req = 1'b1;
    repeat (2) @(negedge clk_sys);
    `CHK("pdn", 1'b0, pdn_n)
    `CHK("mode", MODE_ARRAY, mode)
    cfg.pdn_req = 1'b0;
    xfer(OP_READ, 17'h04011, 1'b0, '0, d2, MODE_ARRAY);
    $display("power down test done");
    // Clock enable low in mid-read must freeze strobes and handshake
    fork
      xfer(OP_READ, 17'h04010, 1'b0, '0, {b, d[7:0]}, MODE_ARRAY);
      begin
        repeat (3) @(negedge clk_sys);
        ce = 1'b0;
        hold = {ce_n, oe_n, ready};
        repeat (4) @(negedge clk_sys);
        `CHK("freeze", hold, {ce_n, oe_n, ready})
        ce = 1'b1;
      end
    join
    $display("clock enable test done");
    complete_run();
  end
endmodule
`default_nettype wire
